// ===== rtl/cell_monitor_control_link.sv
`timescale 1ns/1ps
// How it works
// [R1] balance off: controller writes 0x55, 0xaa, 0x00 to balance register
// [R2] balance on: after clearing sequence, a fourth write selects enabled cells
// [R3] neighbouring cells never enabled together; sequence or pattern violations rejected
// [R4] charge gate output follows its control input
// [R5] discharge gate b output follows its control input
// [R6] discharge gate a output follows its control input
// [R7] controller generates the serial clock; device samples it as input
// [R8] data line bidirectional; device drives low only for acknowledge and reads
// [R9] short-current event gives one low pulse on open-drain interrupt
// [R10] undriven gate control inputs read low, driver off
// [R11] wake flag follows wake input level and reads back over serial bus
// [R12] controller reruns balance-off at power-up and on large cell spread; no cell spread is modelled
// [R13] each write is one full addressed transaction with start and stop
// [R14] balance register holds one enable bit per cell
module cell_monitor_control_link
  import cell_link_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic monitor_sclk_pin,
  input wire logic monitor_sdat_in,
  output logic monitor_sdat_out,
  output logic monitor_sdat_oe,
  input wire logic charge_gate_ctl_in,
  input wire logic charge_gate_ctl_oe,
  input wire logic discharge_gate_b_ctl_in,
  input wire logic discharge_gate_b_ctl_oe,
  input wire logic discharge_gate_a_ctl_in,
  input wire logic discharge_gate_a_ctl_oe,
  input wire logic short_current_det,
  input wire logic high_volt_wake_in,
  output logic charge_gate_out,
  output logic discharge_gate_b_out,
  output logic discharge_gate_a_out,
  output logic short_current_irq_n_out,
  output logic short_current_irq_n_oe,
  output logic external_wake_flag,
  output logic [CELL_COUNT-1:0] balance_enable_reg
);
  logic [8:0] sync_q;
  logic scl_s, sda_s, chg_s, dgb_s, dga_s, sc_s, wk_s;
  logic scl_d_r, sda_d_r, sc_d_r;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] shift_r;
  logic [1:0] phase_r; // 0 addr, 1 reg (read data in a read), 2 write data, 3 ignore
  logic active_r, ack_r, ack_slot_r, rd_r, addressed_r, rd_oe_r;
  logic [7:0] reg_ptr_r;
  seq_t seq_r;
  logic [PULSE_W-1:0] pulse_r;
  logic [7:0] rd_data_r;

  // R10: pull-down model, an undriven input is taken as low
  wire chg_raw = charge_gate_ctl_oe & charge_gate_ctl_in;
  wire dgb_raw = discharge_gate_b_ctl_oe & discharge_gate_b_ctl_in;
  wire dga_raw = discharge_gate_a_ctl_oe & discharge_gate_a_ctl_in;

  pin_sync #(.WIDTH(9)) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .async_in({~monitor_sclk_pin, ~monitor_sdat_in, chg_raw, dgb_raw, dga_raw,
               short_current_det, high_volt_wake_in, 2'b00}),
    .sync_out(sync_q)
  );
  // bus lines pass inverted so the cleared synchroniser reads an idle high bus, no false stop after reset
  assign {scl_s, sda_s, chg_s, dgb_s, dga_s, sc_s, wk_s} = sync_q[8:2] ^ 7'h60;

  // bus condition decode on synchronised levels
  wire start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_c = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire [7:0] byte_v = {shift_r[6:0], sda_s};
  wire byte_done = scl_rise & (bit_cnt_r == 4'd7) & ~ack_r;
  // [R3] no two neighbouring cell bits set together
  wire adjacent_ok = ((byte_v & {byte_v[6:0], 1'b0}) == 8'h00);
  wire bal_write = byte_done & active_r & ~rd_r & (phase_r == 2'd2) & (reg_ptr_r == BAL_REG_ADDR);
  wire addr_hit = (byte_v[7:1] == DEV_ADDR);
  assign bit_cnt_nxt = bit_cnt_r + 4'd1;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      sc_d_r <= 1'b0;
    end
    else
    begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      sc_d_r <= sc_s;
    end
  end

  // [R13] byte framing of a transaction between start and stop
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      active_r <= 1'b0;
      bit_cnt_r <= 4'd0;
      shift_r <= 8'h00;
      phase_r <= 2'd0;
      ack_r <= 1'b0;
      rd_r <= 1'b0;
      addressed_r <= 1'b0;
      reg_ptr_r <= 8'h00;
      ack_slot_r <= 1'b0;
    end
    else if (start_c)
    begin
      active_r <= 1'b1;
      bit_cnt_r <= 4'd0;
      phase_r <= 2'd0;
      ack_r <= 1'b0;
      rd_r <= 1'b0;
      addressed_r <= 1'b0;
      ack_slot_r <= 1'b0;
    end
    else if (stop_c)
    begin
      active_r <= 1'b0;
      ack_r <= 1'b0;
      ack_slot_r <= 1'b0;
      addressed_r <= 1'b0;
    end
    else if (active_r && byte_done)
    begin
      shift_r <= byte_v;
      bit_cnt_r <= 4'd0;
      ack_r <= 1'b1;
      if (phase_r == 2'd0)
      begin
        addressed_r <= addr_hit;
        rd_r <= byte_v[0];
        phase_r <= addr_hit ? 2'd1 : 2'd3;
      end
      else if (phase_r == 2'd1 && !rd_r)
      begin
        reg_ptr_r <= byte_v;
        phase_r <= 2'd2;
      end
      else if (phase_r != 2'd3)
        phase_r <= 2'd3; // one data byte per transaction, read or write
    end
    else if (active_r && scl_rise && !ack_r)
    begin
      shift_r <= byte_v;
      bit_cnt_r <= bit_cnt_nxt;
    end
    // the ninth rise lies inside the slot and is not counted as a bit
    else if (active_r && scl_fall && ack_r)
    begin
      ack_slot_r <= ~ack_slot_r; // first fall opens the slot, second closes it
      ack_r <= ~ack_slot_r;
    end
  end

  // [R8] drive low for ack and for read bits, otherwise release
  wire rd_bit = rd_data_r[3'(4'd7 - bit_cnt_r)];
  wire ack_drive = ack_slot_r & addressed_r & (phase_r != 2'd3 || !rd_r);
  wire rd_oe_nxt = active_r & addressed_r & rd_r & (phase_r == 2'd1) & (~ack_r | ack_slot_r) & ~rd_bit;
  assign monitor_sdat_out = 1'b0;
  assign monitor_sdat_oe = ack_drive | rd_oe_r;

  // [R8] read bits move after a fall; a change while the clock is high would frame a start or a stop
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      rd_oe_r <= 1'b0;
    else if (start_c || stop_c)
      rd_oe_r <= 1'b0;
    else if (scl_fall)
      rd_oe_r <= rd_oe_nxt;
  end

  // [R11] read data chosen by register pointer
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      rd_data_r <= 8'h00;
    else
      rd_data_r <= (reg_ptr_r == WAKE_REG_ADDR) ? {7'h00, external_wake_flag} : balance_enable_reg;
  end

  // a stray first key may itself open a new sequence
  seq_t seq_restart;
  assign seq_restart = (byte_v == UNLOCK_KEY_A) ? SEQ_GOT_A : SEQ_IDLE;

  // [R1] [R2] unlock sequence tracker; any other value restarts it
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      seq_r <= SEQ_IDLE;
    else if (bal_write)
    begin
      unique case (seq_r)
        SEQ_IDLE: seq_r <= seq_restart;
        SEQ_GOT_A: seq_r <= (byte_v == UNLOCK_KEY_B) ? SEQ_GOT_B : seq_restart;
        SEQ_GOT_B: seq_r <= (byte_v == UNLOCK_KEY_C) ? SEQ_ARMED : seq_restart;
        SEQ_ARMED: seq_r <= seq_restart;
      endcase
    end
  end

  // [R14] per-cell enable bits; keys clear, armed write loads if non-adjacent
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      balance_enable_reg <= BAL_RESET_VAL;
    else if (bal_write && seq_r == SEQ_ARMED && adjacent_ok)
      balance_enable_reg <= byte_v;
    else if (bal_write)
      balance_enable_reg <= BAL_RESET_VAL; // a write outside the armed step never reaches cells
  end

  // [R4] [R5] [R6] gate drivers follow synchronised control inputs
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      charge_gate_out <= 1'b0;
      discharge_gate_b_out <= 1'b0;
      discharge_gate_a_out <= 1'b0;
      external_wake_flag <= 1'b0;
    end
    else
    begin
      charge_gate_out <= chg_s;
      discharge_gate_b_out <= dgb_s;
      discharge_gate_a_out <= dga_s;
      external_wake_flag <= wk_s;
    end
  end

  // [R9] one low pulse per rising short-current event outside a running pulse
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      pulse_r <= '0;
    else if (sc_s && !sc_d_r && pulse_r == '0)
      pulse_r <= PULSE_LOAD;
    else if (pulse_r != '0)
      pulse_r <= pulse_r - 1'b1;
  end
  assign short_current_irq_n_out = 1'b0;
  assign short_current_irq_n_oe = (pulse_r != '0);

  // [R3] never two neighbouring cells on
  a_no_adjacent: assert property (@(posedge mclk) disable iff (!reset_n)
    (balance_enable_reg & {balance_enable_reg[6:0], 1'b0}) == 8'h00) else $error("adjacent cells enabled"); // [R3]
  a_load_needs_arm: assert property (@(posedge mclk) disable iff (!reset_n)
    $changed(balance_enable_reg) && balance_enable_reg != 8'h00 |-> $past(seq_r) == SEQ_ARMED)
    else $error("cells enabled without unlock"); // [R2]
  a_key_clears: assert property (@(posedge mclk) disable iff (!reset_n)
    bal_write && seq_r != SEQ_ARMED |=> balance_enable_reg == 8'h00) else $error("key write not clearing"); // [R1]
  a_charge_follow: assert property (@(posedge mclk) disable iff (!reset_n)
    chg_s |=> charge_gate_out) else $error("charge gate lag"); // [R4]
  a_dis_b_follow: assert property (@(posedge mclk) disable iff (!reset_n)
    dgb_s == $past(dgb_s) |=> discharge_gate_b_out == $past(dgb_s)) else $error("gate b mismatch"); // [R5]
  a_dis_a_follow: assert property (@(posedge mclk) disable iff (!reset_n)
    !dga_s |=> !discharge_gate_a_out) else $error("gate a not off"); // [R6]
  a_pulse_width: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(short_current_irq_n_oe) |-> short_current_irq_n_oe [*8]) else $error("irq pulse short"); // [R9]
  a_pulse_ends: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(short_current_irq_n_oe) |-> ##[1:60] !short_current_irq_n_oe) else $error("irq pulse stuck"); // [R9]
  a_pulldown_off: assert property (@(posedge mclk) disable iff (!reset_n)
    !chg_raw [*3] |=> !charge_gate_out) else $error("undriven input not off"); // [R10]
  a_wake_track: assert property (@(posedge mclk) disable iff (!reset_n)
    wk_s |=> external_wake_flag) else $error("wake flag not set"); // [R11]
  a_sdat_scl_low: assert property (@(posedge mclk) disable iff (!reset_n)
    $changed(monitor_sdat_oe) |-> !scl_s) else $error("data line moved while clock high"); // [R8]
  c_enable_cells: cover property (@(posedge mclk) disable iff (!reset_n)
    seq_r == SEQ_ARMED && bal_write && byte_v != 8'h00);
  c_clear_seq: cover property (@(posedge mclk) disable iff (!reset_n) $rose(seq_r == SEQ_ARMED));
  c_irq: cover property (@(posedge mclk) disable iff (!reset_n) $rose(short_current_irq_n_oe));
  c_wake: cover property (@(posedge mclk) disable iff (!reset_n) $rose(external_wake_flag));
  c_read_bit: cover property (@(posedge mclk) disable iff (!reset_n) $rose(rd_oe_r));
endmodule

// ===== inc/cell_link_pkg.sv
package cell_link_pkg;
  localparam int CELL_COUNT = 8;
  localparam logic [6:0] DEV_ADDR = 7'h2a; // arbitrary target address
  localparam logic [7:0] BAL_REG_ADDR = 8'h01;
  localparam logic [7:0] WAKE_REG_ADDR = 8'h02;
  localparam logic [7:0] UNLOCK_KEY_A = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_B = 8'haa;
  localparam logic [7:0] UNLOCK_KEY_C = 8'h00;
  localparam logic [7:0] BAL_RESET_VAL = 8'h00;
  localparam logic [7:0] ODD_CELLS = 8'h55;
  localparam logic [7:0] EVEN_CELLS = 8'haa;
  localparam int PULSE_NS = 1000;
  localparam int CLK_NS = 20;
  localparam int PULSE_CYCLES = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_W = $clog2(PULSE_CYCLES + 1);
  localparam logic [PULSE_W-1:0] PULSE_LOAD = PULSE_W'(PULSE_CYCLES);
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_GOT_A, SEQ_GOT_B, SEQ_ARMED} seq_t;
endpackage

// ===== rtl/pin_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for asynchronous pin levels
module pin_sync
  import cell_link_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  // first stage is read only by the second stage
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// ===== verif/mcu_model.sv
`timescale 1ns/1ps
// controller side: bit-banged serial master with an open-drain data pin
module mcu_model
  import cell_link_pkg::*;
(
  input wire logic mclk,
  input wire logic sdat_line,
  output logic sclk,
  output logic sdat_low
);
  // idle bus: clock high, data released to its pull-up
  initial
  begin
    sclk = 1'b1;
    sdat_low = 1'b0;
  end
  // software clock, five mclk per half
  task automatic half();
    repeat (5) @(posedge mclk);
  endtask
  task automatic put_bit(input logic b, output logic s);
    sdat_low <= ~b;
    half();
    sclk <= 1'b1;
    half();
    s = sdat_line;
    sclk <= 1'b0;
    half();
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] r, input logic [7:0] d,
    output logic [2:0] acks);
    logic [26:0] w;
    logic s;
    w = {a, 1'b1, r, 1'b1, d, 1'b1};
    sdat_low <= 1'b1;
    half();
    sclk <= 1'b0;
    half();
    for (int i = 26; i >= 0; i--)
    begin
      put_bit(w[i], s);
      if (i % 9 == 0)
        acks[i / 9] = ~s; // ack slots are released, so low means the device answered
    end
    sdat_low <= 1'b1;
    half();
    sclk <= 1'b1;
    half();
    sdat_low <= 1'b0;
    half();
  endtask
  // pointer write and stop, then an addressed read of one byte closed by a nack
  task automatic read_reg(input logic [7:0] a, input logic [7:0] r, output logic [7:0] d,
    output logic [2:0] acks);
    logic [17:0] w;
    logic s;
    for (int t = 0; t < 2; t++)
    begin
      w = (t == 0) ? {a, 1'b1, r, 1'b1} : {a | 8'h01, 1'b1, 8'hff, 1'b1};
      sdat_low <= 1'b1;
      half();
      sclk <= 1'b0;
      half();
      for (int i = 17; i >= 0; i--)
      begin
        put_bit(w[i], s);
        if (t == 0 && i % 9 == 0)
          acks[1 + i / 9] = ~s;
        else if (t == 1 && i == 9)
          acks[0] = ~s;
        else if (t == 1 && i > 0 && i < 9)
          d[i - 1] = s; // data line released, so the device's bits show through
      end
      sdat_low <= 1'b1;
      half();
      sclk <= 1'b1;
      half();
      sdat_low <= 1'b0;
      half();
    end
  endtask
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import cell_link_pkg::*;
;
  logic mclk, reset_n, sclk, sdat_low, sdat_line, sdat_out, sdat_oe;
  logic short_det, wake_in, irq_out, irq_oe, wake_flag;
  logic [2:0] ctl_in, ctl_oe, gate_out;
  logic [7:0] bal;
  int failures, comparisons;
  // pulled-up data wire, low if either party pulls
  assign sdat_line = ~(sdat_low | sdat_oe);
  cell_monitor_control_link i_cell_monitor_control_link (.mclk(mclk), .reset_n(reset_n),
    .monitor_sclk_pin(sclk), .monitor_sdat_in(sdat_line), .monitor_sdat_out(sdat_out),
    .monitor_sdat_oe(sdat_oe), .charge_gate_ctl_in(ctl_in[0]), .charge_gate_ctl_oe(ctl_oe[0]),
    .discharge_gate_b_ctl_in(ctl_in[1]), .discharge_gate_b_ctl_oe(ctl_oe[1]),
    .discharge_gate_a_ctl_in(ctl_in[2]), .discharge_gate_a_ctl_oe(ctl_oe[2]),
    .short_current_det(short_det), .high_volt_wake_in(wake_in), .charge_gate_out(gate_out[0]),
    .discharge_gate_b_out(gate_out[1]), .discharge_gate_a_out(gate_out[2]),
    .short_current_irq_n_out(irq_out), .short_current_irq_n_oe(irq_oe),
    .external_wake_flag(wake_flag), .balance_enable_reg(bal));
  mcu_model i_mcu_model (.mclk(mclk), .sdat_line(sdat_line), .sclk(sclk), .sdat_low(sdat_low));
  // 50 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // a write to the balance register must be acknowledged in all three slots
  task automatic bal_write(input logic [7:0] d);
    logic [2:0] acks;
    i_mcu_model.write_reg({DEV_ADDR, 1'b0}, BAL_REG_ADDR, d, acks);
    check({5'h0, acks}, 8'h07);
  endtask
  task automatic unlock();
    bal_write(UNLOCK_KEY_A);
    bal_write(UNLOCK_KEY_B);
    bal_write(UNLOCK_KEY_C);
  endtask
  task automatic t_balance();
    logic [2:0] acks;
    logic [7:0] rd;
    unlock();
    bal_write(ODD_CELLS);
    check(bal, ODD_CELLS);
    bal_write(UNLOCK_KEY_A);
    check(bal, BAL_RESET_VAL);
    bal_write(UNLOCK_KEY_B);
    bal_write(UNLOCK_KEY_C);
    bal_write(EVEN_CELLS);
    check(bal, EVEN_CELLS);
    i_mcu_model.read_reg({DEV_ADDR, 1'b0}, BAL_REG_ADDR, rd, acks);
    check(rd, EVEN_CELLS);
    check({5'h0, acks}, 8'h07);
    unlock();
    check(bal, BAL_RESET_VAL);
    unlock();
    bal_write(8'h03);
    check(bal, BAL_RESET_VAL);
    bal_write(UNLOCK_KEY_B);
    bal_write(UNLOCK_KEY_C);
    bal_write(ODD_CELLS);
    check(bal, BAL_RESET_VAL);
    i_mcu_model.write_reg({DEV_ADDR ^ 7'h01, 1'b0}, BAL_REG_ADDR, ODD_CELLS, acks);
    check({4'h0, acks, bal[0]}, 8'h00);
  endtask
  // each gate alone, then all requested but undriven
  task automatic t_gates();
    for (int g = 0; g < 3; g++)
    begin
      ctl_oe <= 3'h1 << g;
      ctl_in <= 3'h1 << g;
      cyc(6);
      check({5'h0, gate_out}, 8'h01 << g);
    end
    ctl_oe <= 3'h0;
    ctl_in <= 3'h7;
    cyc(6);
    check({5'h0, gate_out}, 8'h00);
  endtask
  // second event inside the pulse must not stretch the pulse
  task automatic t_irq();
    int n;
    n = 0;
    short_det <= 1'b1;
    while (irq_oe !== 1'b1 && n < 20)
    begin
      cyc(1);
      n++;
    end
    n = 0;
    while (irq_oe === 1'b1 && n < 200)
    begin
      if (n == 10)
        short_det <= 1'b0;
      if (n == 20)
        short_det <= 1'b1;
      cyc(1);
      n++;
    end
    if (n == 0 || n >= 200)
    begin
      failures++;
      summarize();
    end
    check(8'(n), 8'(PULSE_CYCLES));
    short_det <= 1'b0;
    cyc(60);
    check({6'h0, irq_oe, irq_out}, 8'h00);
  endtask
  // wake flag level and its read-back over the serial bus
  task automatic t_wake();
    logic [2:0] acks;
    logic [7:0] rd;
    wake_in <= 1'b1;
    cyc(6);
    check({7'h0, wake_flag}, 8'h01);
    i_mcu_model.read_reg({DEV_ADDR, 1'b0}, WAKE_REG_ADDR, rd, acks);
    check(rd, 8'h01);
    check({5'h0, acks}, 8'h07);
    wake_in <= 1'b0;
    cyc(6);
    check({7'h0, wake_flag}, 8'h00);
    i_mcu_model.read_reg({DEV_ADDR, 1'b0}, WAKE_REG_ADDR, rd, acks);
    check(rd, 8'h00);
  endtask
  // main sequence
  initial
  begin
    reset_n = 1'b0;
    ctl_in = 3'h0;
    ctl_oe = 3'h0;
    short_det = 1'b0;
    wake_in = 1'b0;
    failures = 0;
    comparisons = 0;
    cyc(6);
    reset_n <= 1'b1;
    cyc(4);
    check({gate_out, irq_oe, sdat_oe, wake_flag, bal[1:0]}, 8'h00);
    check({7'h0, sdat_out}, 8'h00);
    unlock();
    check(bal, BAL_RESET_VAL);
    t_balance();
    t_gates();
    t_irq();
    t_wake();
    summarize();
  end
endmodule
